// *** hw/fwl_pkg.sv ***
/*
 * Constants for the fault, warning and link-error logger: register
 * offsets, field positions, reset values, event codes and timing counts.
 * Assumes a 125 MHz system clock and a word-aligned register port.
 */
package fwl_pkg;
	// ------------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam int          DATA_W     = 32;
	localparam int          CODE_W     = 8;
	localparam int          RUN_W      = 2;
	localparam int          WRN_N      = 5;
	localparam logic [3:0]  HIST_DEPTH = 4'hA;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_ERR_LIMIT = 8'h08;
	localparam logic [7:0] OFS_TIMEOUT   = 8'h0C;
	localparam logic [7:0] OFS_ERR_CODE  = 8'h10;
	localparam logic [7:0] OFS_COUNTS    = 8'h14;
	localparam logic [1:0] BANK_ALM      = 2'h1;   // 0x40..0x64
	localparam logic [1:0] BANK_WRN      = 2'h2;   // 0x80..0xA4
	localparam logic [1:0] BANK_CER      = 2'h3;   // 0xC0..0xE4

	// ------------------------------------------------------------------
	// Control bits (write one to act) and status fields
	// ------------------------------------------------------------------
	localparam int CTRL_ALM_CLR   = 0;
	localparam int CTRL_ALM_ERASE = 1;
	localparam int CTRL_WRN_ERASE = 2;
	localparam int CTRL_CER_ERASE = 3;
	localparam int ST_ALM_ACT     = 0;
	localparam int ST_ALM_FATAL   = 1;
	localparam int ST_CAUTION     = 2;
	localparam int ST_ALM_CODE    = 8;
	localparam int ST_WRN_CODE    = 16;
	localparam int CNT_ALM        = 0;
	localparam int CNT_WRN        = 8;
	localparam int CNT_CER        = 16;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0]  ERR_LIMIT_RST = 8'h03;
	localparam logic [15:0] TIMEOUT_RST   = 16'h0000;   // Zero disables

	// ------------------------------------------------------------------
	// Event codes
	// ------------------------------------------------------------------
	localparam logic [7:0] WRN_OVERHEAT  = 8'h21;
	localparam logic [7:0] WRN_UNDERVOLT = 8'h25;
	localparam logic [7:0] WRN_OVERLOAD  = 8'h30;
	localparam logic [7:0] WRN_OP_ERR    = 8'h6C;
	localparam logic [7:0] WRN_COMM      = 8'h84;
	localparam logic [7:0] CER_FRAME     = 8'h84;
	localparam logic [7:0] CER_UNDEF     = 8'h88;
	localparam logic [7:0] CER_HMI       = 8'h89;
	localparam logic [7:0] CER_BUSY      = 8'h8A;
	localparam logic [7:0] CER_RANGE     = 8'h8C;
	localparam logic [7:0] CER_NOEXEC    = 8'h8D;
	localparam logic [7:0] ALM_COMM      = 8'h84;
	localparam logic [7:0] ALM_TIMEOUT   = 8'h85;
	localparam logic [7:0] ALM_STORAGE   = 8'h41;

	// ------------------------------------------------------------------
	// Timing: one timeout tick is one millisecond
	// ------------------------------------------------------------------
	localparam int MS_TIME_NS    = 1000000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
endpackage

// *** hw/fwl_logger.sv ***
/*
 * Fault, warning and link-error logger of a motor driver: alarm latch
 * with its clear paths, self-clearing caution output, classification of
 * host command failures and three newest-first histories of ten codes.
 * Assumes a host-side register port on SYS_CLK, a frame decoder on the
 * same clock that pulses FRAME_DONE with its flags, and asynchronous
 * FAULT_CLEAR and RUN_IN pins.
 */
// The plain strobed port and the placing of the registers were left to the implementer.
// Summary of operation
// - A resettable alarm clears on the falling edge of the fault-clear pin.
// - A host clear request over the link also clears a resettable alarm.
// - Run inputs still on after a link clear restart the motor at once.
// - Non-resettable alarms ignore every clear path; only power cycling clears them.
// - Ten newest alarms are kept in non-volatile storage, newest first.
// - The alarm history is returned on its monitor read.
// - The alarm history is erased on its maintenance command.
// - Caution output follows any warning condition, clearing by itself.
// - Overheat, undervoltage and overload warnings report 21h, 25h, 30h.
// - Handheld test-run or reassigned-input conflict raises warning 6Ch.
// - Any link error raises warning 84h.
// - Ten newest warnings are kept, newest first.
// - Warning history is read on monitor and erased on maintenance command.
// - Power off erases the warning history.
// - Ten newest link errors are kept in volatile storage, readable by host.
// - Framing or block-check errors log link error 84h.
// - Undefined commands are refused and log 88h.
// - Commands during handheld communication are refused and log 89h.
// - Storage busy, internal busy or storage alarm refuse commands, log 8Ah.
// - Out-of-range setting writes are refused and log 8Ch.
// - Commands not executable in the present state are refused, log 8Dh.
// - Link-error history is read on monitor and erased on maintenance command.
// - Consecutive link errors reaching the set limit raise alarm 84h.
// - Timeout without valid host traffic raises alarm 85h.
`timescale 1ns/1ns
module fwl_logger #(
	parameter int MS_CYCLES = fwl_pkg::MS_CYCLES
) (
	input  wire logic                       SYS_CLK,
	input  wire logic                       RESET_N,
	input  wire logic [fwl_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [fwl_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                       REG_WR,
	input  wire logic                       REG_RD,
	output logic      [fwl_pkg::DATA_W-1:0] REG_RDATA,
	input  wire logic                       FAULT_CLEAR,
	input  wire logic [fwl_pkg::RUN_W-1:0]  RUN_IN,
	input  wire logic                       HMI_CLEAR,
	input  wire logic                       HMI_BUSY,
	input  wire logic                       HMI_OP_ERR,
	input  wire logic                       ALARM_SET,
	input  wire logic [fwl_pkg::CODE_W-1:0] ALARM_CODE,
	input  wire logic                       ALARM_FATAL,
	input  wire logic                       WARN_OVERHEAT,
	input  wire logic                       WARN_UNDERVOLT,
	input  wire logic                       WARN_OVERLOAD,
	input  wire logic                       FRAME_DONE,
	input  wire logic                       FRAME_ERR,
	input  wire logic                       CMD_UNDEF,
	input  wire logic                       CMD_RANGE,
	input  wire logic                       CMD_NOEXEC,
	input  wire logic                       NVM_BUSY,
	input  wire logic                       INTERNAL_BUSY_FLAG,
	output logic                            CMD_ACCEPT,
	output logic                            CMD_REFUSE,
	output logic      [fwl_pkg::CODE_W-1:0] CMD_ERR_CODE,
	output logic                            ALARM_ACTIVE,
	output logic                            CAUTION_OUTPUT,
	output logic                            RUN_EN
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [2:0]                  fclr_sync_reg;
	logic                        fclr_q_reg;
	logic [fwl_pkg::RUN_W-1:0]   run_s1_reg, run_s2_reg, run_s3_reg, run_q_reg;
	logic                        alm_act_reg, alm_fatal_reg;
	logic [7:0]                  alm_code_reg;
	logic [7:0]                  alm_hist_reg [0:9];
	logic [7:0]                  wrn_hist_reg [0:9];
	logic [7:0]                  cer_hist_reg [0:9];
	logic [3:0]                  alm_cnt_reg, wrn_cnt_reg, cer_cnt_reg;
	logic [fwl_pkg::WRN_N-1:0]   wrn_prev_reg, wrn_pend_reg, wrn_pend_next;
	logic                        comm_warn_reg;
	logic [7:0]                  err_limit_reg, err_run_reg, err_run_next;
	logic [15:0]                 tmo_limit_reg, tmo_ms_reg;
	logic [16:0]                 ms_cnt_reg;
	logic [31:0]                 rd_mux;
	logic                        wr_ctrl, fclr_fall, clr_req, clr_ok, storage_alm;
	logic                        cer_hit, cmd_ok, ms_tick, comm_alm, tmo_alm;
	logic                        alm_raise, alm_latch, alm_fatal_in, wrn_push;
	logic [7:0]                  alm_code_in, cer_code, wrn_code_now, wrn_push_code;
	logic [fwl_pkg::WRN_N-1:0]   wrn_vec, wrn_sel;
	logic [1:0]                  rd_bank;
	logic [3:0]                  rd_idx;

	// Code of the lowest set warning bit, zero if none
	function automatic logic [7:0] wrn_code(input logic [fwl_pkg::WRN_N-1:0] v);
		if (v[0])      return fwl_pkg::WRN_OVERHEAT;
		else if (v[1]) return fwl_pkg::WRN_UNDERVOLT;
		else if (v[2]) return fwl_pkg::WRN_OVERLOAD;
		else if (v[3]) return fwl_pkg::WRN_OP_ERR;
		else if (v[4]) return fwl_pkg::WRN_COMM;
		else           return 8'h00;
	endfunction

	// Entry of a history, zero past its fill level
	function automatic logic [7:0] hist_pick(input logic [7:0] e, input logic [3:0] i,
	                                         input logic [3:0] n);
		return (i < n) ? e : 8'h00;
	endfunction

	// Saturating fill count after one push
	function automatic logic [3:0] cnt_push(input logic [3:0] n);
		return (n == fwl_pkg::HIST_DEPTH) ? n : n + 4'h1;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Three stages; filtered level moves once stages two and three agree
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fclr_sync_reg <= 3'h0;
			fclr_q_reg    <= 1'b0;
			run_s1_reg    <= '0;
			run_s2_reg    <= '0;
			run_s3_reg    <= '0;
			run_q_reg     <= '0;
		end else begin
			fclr_sync_reg <= {fclr_sync_reg[1:0], FAULT_CLEAR};
			if (fclr_sync_reg[1] == fclr_sync_reg[2])
				fclr_q_reg <= fclr_sync_reg[2];
			run_s1_reg <= RUN_IN;
			run_s2_reg <= run_s1_reg;
			run_s3_reg <= run_s2_reg;
			for (int i = 0; i < fwl_pkg::RUN_W; i++) begin
				if (run_s2_reg[i] == run_s3_reg[i])
					run_q_reg[i] <= run_s3_reg[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// Command classification
	// ------------------------------------------------------------------
	// Refusal code in fixed priority, zero when the command is taken
	assign storage_alm = alm_act_reg && (alm_code_reg == fwl_pkg::ALM_STORAGE);
	assign cer_code = FRAME_ERR                    ? fwl_pkg::CER_FRAME  :
	                  CMD_UNDEF                    ? fwl_pkg::CER_UNDEF  :
	                  HMI_BUSY                     ? fwl_pkg::CER_HMI    :
	                  (NVM_BUSY || INTERNAL_BUSY_FLAG || storage_alm)
	                                               ? fwl_pkg::CER_BUSY   :
	                  CMD_RANGE                    ? fwl_pkg::CER_RANGE  :
	                  CMD_NOEXEC                   ? fwl_pkg::CER_NOEXEC :
	                  8'h00;
	assign cer_hit = FRAME_DONE && (cer_code != 8'h00);
	assign cmd_ok  = FRAME_DONE && (cer_code == 8'h00);

	// Answer pulses and the latest refusal code
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CMD_ACCEPT   <= 1'b0;
			CMD_REFUSE   <= 1'b0;
			CMD_ERR_CODE <= 8'h00;
		end else begin
			CMD_ACCEPT <= cmd_ok;
			CMD_REFUSE <= cer_hit;
			if (cer_hit)
				CMD_ERR_CODE <= cer_code;
		end
	end

	// Run of consecutive link errors; limit zero never alarms
	assign err_run_next = cer_hit ? ((err_run_reg == 8'hFF) ? err_run_reg
	                                                        : err_run_reg + 8'h01)
	                    : (cmd_ok ? 8'h00 : err_run_reg);
	assign comm_alm = cer_hit && (err_limit_reg != 8'h00)
	                  && (err_run_next == err_limit_reg);

	// Millisecond ticks since the last valid command
	assign ms_tick = (ms_cnt_reg == 17'(MS_CYCLES - 1));
	assign tmo_alm = ms_tick && (tmo_limit_reg != 16'h0000)
	                 && (tmo_ms_reg + 16'h0001 == tmo_limit_reg);
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			err_run_reg   <= 8'h00;
			comm_warn_reg <= 1'b0;
			ms_cnt_reg    <= 17'h0_0000;
			tmo_ms_reg    <= 16'h0000;
		end else begin
			err_run_reg <= err_run_next;
			if (cer_hit)
				comm_warn_reg <= 1'b1;
			else if (cmd_ok)
				comm_warn_reg <= 1'b0;
			if (cmd_ok || ms_tick)
				ms_cnt_reg <= 17'h0_0000;
			else
				ms_cnt_reg <= ms_cnt_reg + 17'h0_0001;
			if (cmd_ok)
				tmo_ms_reg <= 16'h0000;
			else if (ms_tick && (tmo_ms_reg < tmo_limit_reg))
				tmo_ms_reg <= tmo_ms_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Alarm latch
	// ------------------------------------------------------------------
	// Sources in priority order; clears reach resettable alarms only
	assign wr_ctrl      = REG_WR && (REG_ADDR == fwl_pkg::OFS_CTRL);
	assign fclr_fall    = fclr_q_reg && (fclr_sync_reg[1] == fclr_sync_reg[2])
	                      && !fclr_sync_reg[2];
	assign clr_req      = fclr_fall || HMI_CLEAR
	                      || (wr_ctrl && REG_WDATA[fwl_pkg::CTRL_ALM_CLR]);
	assign clr_ok       = clr_req && alm_act_reg && !alm_fatal_reg;
	assign alm_raise    = ALARM_SET || comm_alm || tmo_alm;
	assign alm_code_in  = ALARM_SET ? ALARM_CODE
	                    : (comm_alm ? fwl_pkg::ALM_COMM : fwl_pkg::ALM_TIMEOUT);
	assign alm_fatal_in = ALARM_SET && ALARM_FATAL;
	assign alm_latch    = alm_raise && (!alm_act_reg || clr_ok);
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			alm_act_reg   <= 1'b0;
			alm_fatal_reg <= 1'b0;
			alm_code_reg  <= 8'h00;
		end else if (alm_latch) begin
			alm_act_reg   <= 1'b1;
			alm_fatal_reg <= alm_fatal_in;
			alm_code_reg  <= alm_code_in;
		end else if (clr_ok) begin
			alm_act_reg   <= 1'b0;
			alm_fatal_reg <= 1'b0;
		end
	end
	assign ALARM_ACTIVE = alm_act_reg;
	assign RUN_EN       = (|run_q_reg) && !alm_act_reg;

	// ------------------------------------------------------------------
	// Histories
	// ------------------------------------------------------------------
	// Alarm history keeps its content through reset, as storage would
	always_ff @(posedge SYS_CLK) begin
		if (wr_ctrl && REG_WDATA[fwl_pkg::CTRL_ALM_ERASE]) begin
			for (int i = 0; i < 10; i++)
				alm_hist_reg[i] <= 8'h00;
			alm_cnt_reg <= 4'h0;
		end else if (alm_latch) begin
			for (int i = 9; i > 0; i--)
				alm_hist_reg[i] <= alm_hist_reg[i-1];
			alm_hist_reg[0] <= alm_code_in;
			alm_cnt_reg     <= cnt_push(alm_cnt_reg);
		end
	end

	// Warning conditions and edge-queued logging
	assign wrn_vec       = {comm_warn_reg, HMI_OP_ERR, WARN_OVERLOAD,
	                        WARN_UNDERVOLT, WARN_OVERHEAT};
	assign wrn_code_now  = wrn_code(wrn_vec);
	assign wrn_sel       = wrn_pend_reg & (~wrn_pend_reg + 5'h01);
	assign wrn_push      = |wrn_pend_reg;
	assign wrn_push_code = wrn_code(wrn_sel);
	assign wrn_pend_next = (wrn_pend_reg & ~wrn_sel) | (wrn_vec & ~wrn_prev_reg);

	// Warning history is lost at power off
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < 10; i++)
				wrn_hist_reg[i] <= 8'h00;
			wrn_cnt_reg    <= 4'h0;
			wrn_prev_reg   <= '0;
			wrn_pend_reg   <= '0;
			CAUTION_OUTPUT <= 1'b0;
		end else begin
			wrn_prev_reg   <= wrn_vec;
			wrn_pend_reg   <= wrn_pend_next;
			CAUTION_OUTPUT <= |wrn_vec;
			if (wr_ctrl && REG_WDATA[fwl_pkg::CTRL_WRN_ERASE]) begin
				for (int i = 0; i < 10; i++)
					wrn_hist_reg[i] <= 8'h00;
				wrn_cnt_reg <= 4'h0;
			end else if (wrn_push) begin
				for (int i = 9; i > 0; i--)
					wrn_hist_reg[i] <= wrn_hist_reg[i-1];
				wrn_hist_reg[0] <= wrn_push_code;
				wrn_cnt_reg     <= cnt_push(wrn_cnt_reg);
			end
		end
	end

	// Link-error history and configuration registers
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < 10; i++)
				cer_hist_reg[i] <= 8'h00;
			cer_cnt_reg   <= 4'h0;
			err_limit_reg <= fwl_pkg::ERR_LIMIT_RST;
			tmo_limit_reg <= fwl_pkg::TIMEOUT_RST;
		end else begin
			if (wr_ctrl && REG_WDATA[fwl_pkg::CTRL_CER_ERASE]) begin
				for (int i = 0; i < 10; i++)
					cer_hist_reg[i] <= 8'h00;
				cer_cnt_reg <= 4'h0;
			end else if (cer_hit) begin
				for (int i = 9; i > 0; i--)
					cer_hist_reg[i] <= cer_hist_reg[i-1];
				cer_hist_reg[0] <= cer_code;
				cer_cnt_reg     <= cnt_push(cer_cnt_reg);
			end
			if (REG_WR && (REG_ADDR == fwl_pkg::OFS_ERR_LIMIT))
				err_limit_reg <= REG_WDATA[7:0];
			if (REG_WR && (REG_ADDR == fwl_pkg::OFS_TIMEOUT))
				tmo_limit_reg <= REG_WDATA[15:0];
		end
	end

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	// Bank and index decode; unmapped words read zero
	assign rd_bank = REG_ADDR[7:6];
	assign rd_idx  = REG_ADDR[5:2];
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (REG_ADDR[1:0] != 2'h0) begin
			rd_mux = 32'h0000_0000;
		end else if (rd_bank == fwl_pkg::BANK_ALM && rd_idx < fwl_pkg::HIST_DEPTH) begin
			rd_mux[7:0] = hist_pick(alm_hist_reg[rd_idx], rd_idx, alm_cnt_reg);
		end else if (rd_bank == fwl_pkg::BANK_WRN && rd_idx < fwl_pkg::HIST_DEPTH) begin
			rd_mux[7:0] = hist_pick(wrn_hist_reg[rd_idx], rd_idx, wrn_cnt_reg);
		end else if (rd_bank == fwl_pkg::BANK_CER && rd_idx < fwl_pkg::HIST_DEPTH) begin
			rd_mux[7:0] = hist_pick(cer_hist_reg[rd_idx], rd_idx, cer_cnt_reg);
		end else if (REG_ADDR == fwl_pkg::OFS_STATUS) begin
			rd_mux[fwl_pkg::ST_ALM_ACT]        = alm_act_reg;
			rd_mux[fwl_pkg::ST_ALM_FATAL]      = alm_fatal_reg;
			rd_mux[fwl_pkg::ST_CAUTION]        = CAUTION_OUTPUT;
			rd_mux[fwl_pkg::ST_ALM_CODE +: 8]  = alm_code_reg;
			rd_mux[fwl_pkg::ST_WRN_CODE +: 8]  = wrn_code_now;
		end else if (REG_ADDR == fwl_pkg::OFS_ERR_LIMIT) begin
			rd_mux[7:0] = err_limit_reg;
		end else if (REG_ADDR == fwl_pkg::OFS_TIMEOUT) begin
			rd_mux[15:0] = tmo_limit_reg;
		end else if (REG_ADDR == fwl_pkg::OFS_ERR_CODE) begin
			rd_mux[7:0] = CMD_ERR_CODE;
		end else if (REG_ADDR == fwl_pkg::OFS_COUNTS) begin
			rd_mux[fwl_pkg::CNT_ALM +: 4] = alm_cnt_reg;
			rd_mux[fwl_pkg::CNT_WRN +: 4] = wrn_cnt_reg;
			rd_mux[fwl_pkg::CNT_CER +: 4] = cer_cnt_reg;
		end
	end

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N)
			REG_RDATA <= 32'h0000_0000;
		else
			REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_fall_clear;
		fclr_fall && alm_act_reg && !alm_fatal_reg && !alm_raise;
	endsequence
	sequence s_host_clear;
		wr_ctrl && REG_WDATA[fwl_pkg::CTRL_ALM_CLR] && alm_act_reg && !alm_fatal_reg
		&& !alm_raise;
	endsequence
	sequence s_undef_frame;
		FRAME_DONE && !FRAME_ERR && CMD_UNDEF;
	endsequence

	a_fall_clears: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		s_fall_clear |=> !ALARM_ACTIVE)
		else $error("alarm not cleared on fault-clear fall");
	a_rise_keeps: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		$rose(fclr_q_reg) && alm_act_reg && !HMI_CLEAR && !wr_ctrl |=> ALARM_ACTIVE)
		else $error("alarm cleared on fault-clear rise");
	a_host_clears: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		s_host_clear |=> !ALARM_ACTIVE ##0 (RUN_EN == (|run_q_reg)))
		else $error("host clear failed");
	a_run_resume: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		$fell(alm_act_reg) && (|run_q_reg) |-> RUN_EN)
		else $error("motor did not resume after clear");
	a_fatal_holds: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		alm_act_reg && alm_fatal_reg |=> ALARM_ACTIVE && alm_fatal_reg)
		else $error("non-resettable alarm cleared");
	a_alarm_logged: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		alm_latch && !(wr_ctrl && REG_WDATA[fwl_pkg::CTRL_ALM_ERASE])
		|=> alm_hist_reg[0] == $past(alm_code_in) && alm_hist_reg[1] == $past(alm_hist_reg[0]))
		else $error("alarm history not pushed");
	a_caution_follow: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		##1 CAUTION_OUTPUT == $past(|wrn_vec))
		else $error("caution output wrong");
	a_undef_refuse: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		s_undef_frame |=> CMD_REFUSE && !CMD_ACCEPT && CMD_ERR_CODE == fwl_pkg::CER_UNDEF)
		else $error("undefined command not refused");
	a_hmi_refuse: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		FRAME_DONE && !FRAME_ERR && !CMD_UNDEF && HMI_BUSY
		|=> CMD_REFUSE && CMD_ERR_CODE == fwl_pkg::CER_HMI)
		else $error("busy handheld refusal wrong");
	a_comm_alarm: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		comm_alm && !ALARM_SET && !alm_act_reg |=> ALARM_ACTIVE
		&& alm_code_reg == fwl_pkg::ALM_COMM)
		else $error("link error alarm not raised");
	a_erase_hist: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		wr_ctrl && REG_WDATA[fwl_pkg::CTRL_CER_ERASE] |=> cer_cnt_reg == 4'h0)
		else $error("link error history not erased");
	a_read_slot: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		REG_RD |=> REG_RDATA == $past(rd_mux) ##1 (REG_RDATA == 32'h0000_0000 || $past(REG_RD)))
		else $error("read data timing wrong");
endmodule // fwl_logger

// *** tb/fwl_host_model.sv ***
/* Host controller model: issues one frame per go pulse.
   Assumes the logger's clock and reset. */
`timescale 1ns/1ns
module fwl_host_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [2:0] kind,
	output logic      [6:0] fr
);
	// Frame strobe with one failure flag for each of kinds 1 to 6, none for kinds 0 and 7; flags low between frames
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) fr <= '0;
		else fr <= go ? {kind == 3'h6, kind == 3'h5, kind == 3'h4,
			kind == 3'h3, kind == 3'h2, kind == 3'h1, 1'b1} : '0;
endmodule // fwl_host_model

// *** tb/testbench.sv ***
/* Self-checking bench of the logger.
   Assumes the host model and a 125 MHz clock. */
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
	$display("BAD %0t %h %h", $time, a, e); end end
module testbench;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, fclr = 0, hclr = 0, aset = 0, afat = 0;
	logic        go = 0, busy = 0, acc, rfs, act, caut, run_en;
	logic [7:0]  addr = '0, acode = '0, code;
	logic [31:0] wdata = '0, rdata;
	logic [1:0]  run = '0;
	logic [3:0]  wrn = '0;
	logic [2:0]  kind = '0;
	logic [6:0]  fr;
	logic [7:0]  cer [7] = '{8'h00, 8'h84, 8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D};
	logic [7:0]  wcd [4] = '{8'h21, 8'h25, 8'h30, 8'h6C};
	int          num_errors = 0, checks = 0;
	always #4 clk = ~clk;
	fwl_host_model u_fwl_host_model (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind), .fr(fr));
	fwl_logger #(.MS_CYCLES(10)) u_fwl_logger (.SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FAULT_CLEAR(fclr),
		.RUN_IN(run), .HMI_CLEAR(hclr), .HMI_BUSY(fr[3]), .HMI_OP_ERR(wrn[3]), .ALARM_SET(aset),
		.ALARM_CODE(acode), .ALARM_FATAL(afat), .WARN_OVERHEAT(wrn[0]), .WARN_UNDERVOLT(wrn[1]),
		.WARN_OVERLOAD(wrn[2]), .FRAME_DONE(fr[0]), .FRAME_ERR(fr[1]), .CMD_UNDEF(fr[2]),
		.CMD_RANGE(fr[5]), .CMD_NOEXEC(fr[6]), .NVM_BUSY(fr[4]), .INTERNAL_BUSY_FLAG(busy),
		.CMD_ACCEPT(acc), .CMD_REFUSE(rfs), .CMD_ERR_CODE(code), .ALARM_ACTIVE(act),
		.CAUTION_OUTPUT(caut), .RUN_EN(run_en));
	// Bus, frame and alarm helpers
	task automatic cyc(int n); repeat (n) @(posedge clk); #1; endtask
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 0;
	endtask
	task automatic rreg(logic [7:0] a, int sh, logic [7:0] e);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
		#1 `CHK(8'(rdata >> sh), e)
	endtask
	task automatic frame(logic [2:0] k, logic [7:0] e);
		@(posedge clk) {go, kind} <= {1'b1, k};
		@(posedge clk) go <= 0;
		cyc(1);
		`CHK({acc, rfs, code}, {k == 0, k != 0, e})
	endtask
	task automatic alarm(logic [7:0] c, logic f);
		@(posedge clk) {aset, acode, afat} <= {1'b1, c, f};
		@(posedge clk) aset <= 0;
		cyc(2);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog
	initial begin
		cyc(20000);
		num_errors++;
		finish_test;
	end
	// Main sequence
	initial begin
		cyc(12);
		rst_n <= 1;
		wreg(8'h00, 32'h0000_000F);
		for (int k = 1; k < 7; k++) frame(k[2:0], cer[k]);
		`CHK({act, caut}, 2'b11)
		rreg(8'h04, 8, 8'h84);
		rreg(8'h40, 0, 8'h84);
		rreg(8'hC0, 0, 8'h8D);
		rreg(8'hD4, 0, 8'h84);
		frame(0, 8'h8D);
		@(posedge clk) {run, fclr} <= 3'b011;
		cyc(8);
		`CHK({act, run_en, caut}, 3'b100)
		@(posedge clk) fclr <= 0;
		cyc(8);
		`CHK({act, run_en}, 2'b01)
		alarm(8'h25, 0);
		`CHK({act, run_en}, 2'b10)
		wreg(8'h00, 32'h0000_0001);
		cyc(2);
		`CHK({act, run_en}, 2'b01)
		rreg(8'h44, 0, 8'h84);
		$display("alarm and link tests done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) wrn <= 4'(1 << i);
			cyc(3);
			`CHK(caut, 1'b1)
			rreg(8'h04, 16, wcd[i]);
			@(posedge clk) wrn <= 0;
			cyc(3);
			`CHK(caut, 1'b0)
		end
		rreg(8'h80, 0, 8'h6C);
		rreg(8'h14, 8, 8'h05);
		$display("warning tests done");
		@(posedge clk) busy <= 1;
		frame(3'h7, 8'h8A);
		busy <= 0;
		wreg(8'h00, 32'h0000_0008);
		for (int i = 0; i < 11; i++) frame(i[0] ? 3'h2 : 3'h1, cer[i[0] ? 2 : 1]);
		rreg(8'hC0, 0, 8'h84);
		rreg(8'hE4, 0, 8'h88);
		rreg(8'h14, 16, 8'h0A);
		@(posedge clk) hclr <= 1;
		@(posedge clk) hclr <= 0;
		cyc(2);
		`CHK(act, 1'b0)
		alarm(8'h41, 1);
		wreg(8'h00, 32'h0000_0001);
		@(posedge clk) hclr <= 1;
		@(posedge clk) hclr <= 0;
		frame(3'h7, 8'h8A);
		`CHK(act, 1'b1)
		@(posedge clk) rst_n <= 0;
		cyc(3);
		rst_n <= 1;
		`CHK(act, 1'b0)
		rreg(8'h40, 0, 8'h41);
		rreg(8'h14, 8, 8'h00);
		wreg(8'h00, 32'h0000_0002);
		rreg(8'h40, 0, 8'h00);
		wreg(8'h0C, 32'h0000_0002);
		cyc(30);
		rreg(8'h04, 8, 8'h85);
		$display("history tests done");
		finish_test;
	end
endmodule // testbench
